// ---- inc/mlis_pkg.sv ----
// Package with states, character codes and timing constants for link bring-up.
package mlis_pkg;

  typedef enum logic [2:0] {
    ST_QUIET,
    ST_LISTEN,
    ST_PROBE,
    ST_WIDE,
    ST_NARROW_PRI,
    ST_NARROW_ALT
  } mlis_init_e;

  typedef enum logic [1:0] {
    SU_IDLE,
    SU_SEEK_PARTNER,
    SU_CONFIRM,
    SU_NORMAL
  } mlis_start_e;

  localparam int          LANES          = 4;
  localparam int          QUIET_US       = 50;
  localparam int          CLK_MHZ        = 200;
  localparam int          QUIET_CYC      = QUIET_US * CLK_MHZ;
  localparam int          PROBE_US       = 30;
  localparam int          PROBE_CYC      = PROBE_US * CLK_MHZ;
  localparam int          STATUS_GAP     = 1024;
  localparam logic [4:0]  MIN_TX_STATUS  = 5'h0_00F;
  localparam logic [2:0]  MIN_RX_STATUS  = 3'h0_6;
  localparam logic [7:0]  CHAR_IDLE_K    = 8'h0_0BC;
  localparam logic [7:0]  CHAR_PLAIN_K   = 8'h0_01C;
  localparam logic [7:0]  CHAR_FRAME_K   = 8'h0_07C;
  localparam logic [10:0] GAP_ONE_LANE   = 11'h0_001;
  localparam logic [10:0] GAP_FOUR_LANE  = 11'h0_004;
  localparam logic [1:0]  LANE_PRI       = 2'h0_0;
  localparam logic [1:0]  LANE_ALT       = 2'h0_2;

endpackage

// ---- rtl/mlis_gap_counter.sv ----
// Code-group interval counter that raises a due flag every 1024 groups sent.
`timescale 1ns/1ps
module mlis_gap_counter
  import mlis_pkg::*;
(
  input  wire logic        clk,      // System clock.
  input  wire logic        nrst,     // Asynchronous active low reset.
  input  wire logic        clear,    // Restarts the interval.
  input  wire logic [10:0] step,     // Code-groups sent this cycle.
  output logic             due       // Interval reached.
);

  logic [11:0] count_r;

  // The step is the aggregate across active lanes, so a wide link counts four per cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= '0;
    end else if (clear) begin
      // The symbol's own cycle already counts toward the next interval.
      count_r <= {1'b0, step};
    end else if (!due) begin
      count_r <= count_r + {1'b0, step};
    end
  end

  assign due = (count_r >= 12'(STATUS_GAP));

endmodule

// ---- rtl/mlis_link_init.sv ----
// Link initialization state machine and status-symbol startup handshake.
`timescale 1ns/1ps
module mlis_link_init
  import mlis_pkg::*;
#(
  parameter int QUIET_CYCLES = QUIET_CYC,   // Quiet-period length in clocks.
  parameter int PROBE_CYCLES = PROBE_CYC    // Probe-window length in clocks.
)
(
  input  wire logic       SYS_CLK,           // 200 MHz character clock.
  input  wire logic       NRST,              // Asynchronous active low reset.
  input  wire logic [3:0] LANE_LOCK,         // Per-lane code-group lock.
  input  wire logic       LANES_DESKEWED,    // All four lanes aligned.
  input  wire logic       RESTART_REQ,       // Restart-link request.
  input  wire logic       SINGLE_LANE_REQ,   // Force single-lane operation.
  input  wire logic       ALT_LANE_PREF,     // Prefer lane 2 in forced single-lane mode.
  input  wire logic       RX_STATUS_OK,      // Error-free status symbol received.
  input  wire logic       RX_ERROR,          // Receive error detected.
  input  wire logic       PKT_REQ,           // Packet wants to start.
  input  wire logic       ACK_REQ,           // Acknowledge symbol pending.
  input  wire logic       RESP_REQ,          // Response packet is ready.
  input  wire logic       CSYM_REQ,          // Other non-status symbol pending.
  input  wire logic       CSYM_IS_FRAME,     // Pending symbol delimits a packet.
  input  wire logic       CSYM_HAS_BUF,      // Pending symbol carries buffer status.
  output logic [3:0]      LANE_DRV_EN,       // Lane output driver enables.
  output logic            LINK_UP,           // Port initialized.
  output logic            WIDE_MODE,         // Running on four lanes.
  output logic            ALT_LANE_SEL,      // Receive on lane 2.
  output logic            NORMAL_OP,         // Startup handshake finished.
  output logic [7:0]      TX_CHAR,           // Character to stripe and encode.
  output logic            TX_CHAR_K,         // Character is special.
  output logic            TX_STATUS_SYM,     // Status symbol starts this cycle.
  output logic            TX_CSYM_GNT,       // Pending symbol sent this cycle.
  output logic            TX_ACK_GNT,        // Acknowledge sent this cycle.
  output logic            TX_PKT_GNT,        // Packet may start this cycle.
  output logic            TX_RESP_GNT        // Response may start this cycle.
);

  mlis_init_e  state_r;
  mlis_init_e  state_nxt;
  mlis_start_e su_r;
  logic [31:0] timer_r;
  logic        timer_done;
  logic        first_lock_alt_r;
  logic        lock_pri;
  logic        lock_alt;
  logic        link_up_nxt;
  logic [4:0]  tx_cnt_r;
  logic [2:0]  rx_cnt_r;
  logic        ack_sent_r;
  logic        gap_due;
  logic        gap_clear;
  logic [10:0] gap_step;
  logic        send_status;
  logic        send_csym;
  logic        send_ack;
  logic        allow_pkt;

  assign lock_pri   = LANE_LOCK[LANE_PRI];
  assign lock_alt   = LANE_LOCK[LANE_ALT];
  assign timer_done = (timer_r == 32'd0);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_QUIET: begin
        if (timer_done) begin
          state_nxt = ST_LISTEN;
        end
      end
      ST_LISTEN: begin
        if (lock_pri || lock_alt) begin
          if (!SINGLE_LANE_REQ) begin
            state_nxt = ST_PROBE;
          end else if (ALT_LANE_PREF && lock_alt) begin
            state_nxt = ST_NARROW_ALT;
          end else if (lock_pri && lock_alt) begin
            state_nxt = first_lock_alt_r ? ST_NARROW_ALT : ST_NARROW_PRI;
          end else begin
            state_nxt = lock_pri ? ST_NARROW_PRI : ST_NARROW_ALT;
          end
        end
      end
      ST_PROBE: begin
        if (LANES_DESKEWED) begin
          state_nxt = ST_WIDE;
        end else if (!lock_pri && !lock_alt) begin
          state_nxt = ST_QUIET;
        end else if (timer_done) begin
          state_nxt = lock_pri ? ST_NARROW_PRI : ST_NARROW_ALT;
        end
      end
      ST_WIDE: begin
        if (!LANES_DESKEWED) begin
          state_nxt = (!lock_pri && !lock_alt) ? ST_QUIET : ST_PROBE;
        end
      end
      ST_NARROW_PRI: begin
        if (!lock_pri) begin
          state_nxt = ST_QUIET;
        end
      end
      ST_NARROW_ALT: begin
        if (!lock_alt) begin
          state_nxt = ST_QUIET;
        end
      end
      default: begin
        state_nxt = ST_QUIET;
      end
    endcase
    if (RESTART_REQ) begin
      state_nxt = ST_QUIET;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= ST_QUIET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The timer reloads on each entry to quiet or probe and counts down to zero.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      timer_r <= 32'(QUIET_CYCLES);
    end else if (state_nxt == ST_QUIET && (state_r != ST_QUIET || RESTART_REQ)) begin
      timer_r <= 32'(QUIET_CYCLES);
    end else if (state_nxt == ST_PROBE && state_r != ST_PROBE) begin
      timer_r <= 32'(PROBE_CYCLES);
    end else if (!timer_done) begin
      timer_r <= timer_r - 32'd1;
    end
  end

  // Remember which candidate lane locked first while listening.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      first_lock_alt_r <= 1'b0;
    end else if (state_r != ST_LISTEN) begin
      first_lock_alt_r <= 1'b0;
    end else if (lock_alt && !lock_pri) begin
      first_lock_alt_r <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      LANE_DRV_EN  <= 4'h0_0;
      WIDE_MODE    <= 1'b0;
      ALT_LANE_SEL <= 1'b0;
    end else begin
      case (state_nxt)
        ST_QUIET:      LANE_DRV_EN <= 4'h0_0;
        ST_LISTEN:     LANE_DRV_EN <= 4'h0_5;
        default:       LANE_DRV_EN <= 4'h0_F;
      endcase
      WIDE_MODE    <= (state_nxt == ST_WIDE);
      ALT_LANE_SEL <= (state_nxt == ST_NARROW_ALT);
    end
  end

  assign link_up_nxt = (state_nxt == ST_WIDE) || (state_nxt == ST_NARROW_PRI)
                       || (state_nxt == ST_NARROW_ALT);

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      LINK_UP <= 1'b0;
    end else begin
      LINK_UP <= link_up_nxt;
    end
  end

  // Startup handshake: seek a partner status symbol, then count both directions.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      su_r     <= SU_IDLE;
      tx_cnt_r <= '0;
      rx_cnt_r <= '0;
    end else if (!LINK_UP) begin
      su_r     <= SU_IDLE;
      tx_cnt_r <= '0;
      rx_cnt_r <= '0;
    end else begin
      case (su_r)
        SU_IDLE: begin
          su_r <= SU_SEEK_PARTNER;
        end
        SU_SEEK_PARTNER: begin
          if (RX_STATUS_OK && !RX_ERROR) begin
            su_r <= SU_CONFIRM;
          end
        end
        SU_CONFIRM: begin
          if (send_status && tx_cnt_r != MIN_TX_STATUS) begin
            tx_cnt_r <= tx_cnt_r + 5'd1;
          end
          if (RX_ERROR) begin
            rx_cnt_r <= '0;
          end else if (RX_STATUS_OK && rx_cnt_r != MIN_RX_STATUS) begin
            rx_cnt_r <= rx_cnt_r + 3'd1;
          end
          if (tx_cnt_r == MIN_TX_STATUS && rx_cnt_r == MIN_RX_STATUS) begin
            su_r <= SU_NORMAL;
          end
        end
        SU_NORMAL: begin
          su_r <= SU_NORMAL;
        end
        default: begin
          su_r <= SU_IDLE;
        end
      endcase
    end
  end

  // The interval is counted in aggregate code-groups, four per clock on a wide link.
  assign gap_step  = WIDE_MODE ? GAP_FOUR_LANE : GAP_ONE_LANE;
  assign gap_clear = !LINK_UP || send_status || (send_csym && CSYM_HAS_BUF);

  mlis_gap_counter u_gap (
    .clk   (SYS_CLK),
    .nrst  (NRST),
    .clear (gap_clear),
    .step  (gap_step),
    .due   (gap_due)
  );

  // Transmit arbitration; symbols only ever leave once link-up stands.
  always_comb begin
    send_status = 1'b0;
    send_csym   = 1'b0;
    send_ack    = 1'b0;
    allow_pkt   = 1'b0;
    if (LINK_UP && link_up_nxt) begin
      case (su_r)
        SU_SEEK_PARTNER: send_status = gap_due;
        SU_CONFIRM:      send_status = (tx_cnt_r != MIN_TX_STATUS);
        SU_NORMAL: begin
          if (ACK_REQ) begin
            send_ack = 1'b1;
          end else if (CSYM_REQ) begin
            send_csym = 1'b1;
          end else if (gap_due) begin
            send_status = 1'b1;
          end else begin
            allow_pkt = 1'b1;
          end
        end
        default: send_status = 1'b0;
      endcase
    end
  end

  // A response may only follow once its acknowledge has been sent.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ack_sent_r <= 1'b0;
    end else if (!LINK_UP) begin
      ack_sent_r <= 1'b0;
    end else if (send_ack) begin
      ack_sent_r <= 1'b1;
    end else if (allow_pkt && RESP_REQ) begin
      // Cleared at the grant decision so one acknowledge never frees two responses.
      ack_sent_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      TX_CHAR       <= CHAR_IDLE_K;
      TX_CHAR_K     <= 1'b1;
      TX_STATUS_SYM <= 1'b0;
      TX_CSYM_GNT   <= 1'b0;
      TX_ACK_GNT    <= 1'b0;
      TX_PKT_GNT    <= 1'b0;
      TX_RESP_GNT   <= 1'b0;
      NORMAL_OP     <= 1'b0;
    end else begin
      TX_CHAR_K     <= 1'b1;
      if (send_csym && CSYM_IS_FRAME) begin
        TX_CHAR <= CHAR_FRAME_K;
      end else if (send_csym || send_ack || send_status) begin
        TX_CHAR <= CHAR_PLAIN_K;
      end else begin
        TX_CHAR <= CHAR_IDLE_K;
      end
      TX_STATUS_SYM <= send_status;
      TX_CSYM_GNT   <= send_csym;
      TX_ACK_GNT    <= send_ack;
      TX_PKT_GNT    <= allow_pkt && PKT_REQ && !(RESP_REQ && ack_sent_r);
      TX_RESP_GNT   <= allow_pkt && RESP_REQ && ack_sent_r;
      NORMAL_OP     <= LINK_UP && link_up_nxt && (su_r == SU_NORMAL);
    end
  end

endmodule

// ---- verif/mlis_link_init_properties.sv ----
// Concurrent checks on the ports of the link bring-up block.
`timescale 1ns/1ps
module mlis_link_init_properties
  import mlis_pkg::*;
(
  input wire logic       SYS_CLK,          // Clock.
  input wire logic       NRST,             // Reset, active low.
  input wire logic [3:0] LANE_LOCK,        // Lane locks.
  input wire logic       LANES_DESKEWED,   // Deskew.
  input wire logic       RESTART_REQ,      // Restart.
  input wire logic       SINGLE_LANE_REQ,  // Force narrow.
  input wire logic       RX_STATUS_OK,     // Status seen.
  input wire logic       RX_ERROR,         // Receive error.
  input wire logic       CSYM_IS_FRAME,    // Frame symbol.
  input wire logic [3:0] LANE_DRV_EN,      // Drivers.
  input wire logic       LINK_UP,          // Initialized.
  input wire logic       WIDE_MODE,        // Four lanes.
  input wire logic       ALT_LANE_SEL,     // Lane 2.
  input wire logic       NORMAL_OP,        // Normal.
  input wire logic [7:0] TX_CHAR,          // Character.
  input wire logic       TX_CHAR_K,        // Special.
  input wire logic       TX_STATUS_SYM,    // Status sent.
  input wire logic       TX_CSYM_GNT,      // Symbol sent.
  input wire logic       TX_ACK_GNT,       // Ack sent.
  input wire logic       TX_PKT_GNT,       // Packet start.
  input wire logic       TX_RESP_GNT       // Response start.
);
  logic       ack_seen_r;
  logic [4:0] tx_cnt_r;
  logic [3:0] rx_run_r;
  logic       probe;
  logic       any_gnt;
  assign probe   = (LANE_DRV_EN == 4'hF) && !LINK_UP;
  assign any_gnt = TX_STATUS_SYM | TX_CSYM_GNT | TX_ACK_GNT | TX_PKT_GNT | TX_RESP_GNT;
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) ack_seen_r <= 1'b0;
    else if (TX_ACK_GNT) ack_seen_r <= 1'b1;
    else if (TX_RESP_GNT) ack_seen_r <= 1'b0;
  end
  // Counts saturate so a long seek phase cannot wrap them back below the limits.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) tx_cnt_r <= 5'h00;
    else if (!LINK_UP) tx_cnt_r <= 5'h00;
    else if (TX_STATUS_SYM && tx_cnt_r != 5'h1F) tx_cnt_r <= tx_cnt_r + 5'h01;
  end
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) rx_run_r <= 4'h0;
    else if (!LINK_UP || RX_ERROR) rx_run_r <= 4'h0;
    else if (RX_STATUS_OK && rx_run_r != 4'hF) rx_run_r <= rx_run_r + 4'h1;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  drv_legal_a: assert property (
    LANE_DRV_EN inside {4'h0, 4'h5, 4'hF}) else $error("Illegal driver enables.");
  link_idle_a: assert property (
    !LINK_UP |-> TX_CHAR == CHAR_IDLE_K && TX_CHAR_K && !any_gnt)
    else $error("Symbol sent while link down.");
  idle_fill_a: assert property (
    !any_gnt |-> TX_CHAR == CHAR_IDLE_K && TX_CHAR_K) else $error("Gap not idle.");
  status_mark_a: assert property (
    TX_STATUS_SYM |-> TX_CHAR == CHAR_PLAIN_K && TX_CHAR_K) else $error("Status marker.");
  csym_mark_a: assert property (
    TX_CSYM_GNT |-> TX_CHAR_K && TX_CHAR == ($past(CSYM_IS_FRAME) ? CHAR_FRAME_K : CHAR_PLAIN_K))
    else $error("Symbol marker.");
  normal_gate_a: assert property (
    (TX_CSYM_GNT || TX_ACK_GNT || TX_PKT_GNT || TX_RESP_GNT) |-> NORMAL_OP)
    else $error("Traffic before normal.");
  restart_quiet_a: assert property (
    RESTART_REQ |=> !LINK_UP && LANE_DRV_EN == 4'h0) else $error("Restart ignored.");
  probe_entry_a: assert property (
    LANE_DRV_EN == 4'h5 && !SINGLE_LANE_REQ && (LANE_LOCK[0] || LANE_LOCK[2]) && !RESTART_REQ
    |=> probe) else $error("Probe not entered.");
  probe_wide_a: assert property (
    probe && LANES_DESKEWED && !RESTART_REQ |=> WIDE_MODE && LINK_UP)
    else $error("Wide not entered.");
  probe_lost_a: assert property (
    probe && !LANE_LOCK[0] && !LANE_LOCK[2] && !LANES_DESKEWED && !RESTART_REQ
    |=> LANE_DRV_EN == 4'h0) else $error("Probe kept without locks.");
  wide_lost_a: assert property (
    WIDE_MODE && !LANES_DESKEWED && (LANE_LOCK[0] || LANE_LOCK[2]) && !RESTART_REQ
    |=> probe) else $error("Wide loss did not return to probe.");
  wide_up_a: assert property (
    WIDE_MODE |-> LINK_UP && !ALT_LANE_SEL) else $error("Wide flag outside wide state.");
  resp_order_a: assert property (
    TX_RESP_GNT |-> ack_seen_r) else $error("Response before acknowledge.");
  norm_count_a: assert property (
    $rose(NORMAL_OP) |-> tx_cnt_r >= 5'h0F && rx_run_r >= 4'h6)
    else $error("Normal entered early.");
endmodule
bind mlis_link_init mlis_link_init_properties i_props (.*);

// ---- verif/mlis_link_init_test.sv ----
// Self-checking bench for the link bring-up block.
`timescale 1ns/1ps
module mlis_link_init_test
  import mlis_pkg::*;
();
  localparam int QC = 20;
  localparam int PC = 20;
  logic SYS_CLK = 1'b0, NRST = 1'b0, RESTART_REQ = 1'b0, SINGLE_LANE_REQ = 1'b0;
  logic ALT_LANE_PREF = 1'b0, PKT_REQ = 1'b0, ACK_REQ = 1'b0, RESP_REQ = 1'b0;
  logic CSYM_REQ = 1'b0, CSYM_IS_FRAME = 1'b0, wide_ok = 1'b0, status_go = 1'b0;
  logic err_go = 1'b0, CSYM_HAS_BUF = 1'b0;
  logic [3:0] lane_ok = 4'h0;
  logic [3:0] LANE_LOCK, LANE_DRV_EN;
  logic LANES_DESKEWED, RX_STATUS_OK, RX_ERROR, LINK_UP, WIDE_MODE, ALT_LANE_SEL, NORMAL_OP;
  logic TX_CHAR_K, TX_STATUS_SYM, TX_CSYM_GNT, TX_ACK_GNT, TX_PKT_GNT, TX_RESP_GNT;
  logic [7:0] TX_CHAR;
  logic [6:0] sig;
  int num_errors = 0;
  int total_checks = 0;
  int n;
  assign sig = {NORMAL_OP, LINK_UP, TX_RESP_GNT, TX_PKT_GNT, TX_ACK_GNT, TX_CSYM_GNT,
                TX_STATUS_SYM};
  always #2.5 SYS_CLK = ~SYS_CLK;
  mlis_link_init #(.QUIET_CYCLES(QC), .PROBE_CYCLES(PC)) i_dut (.SYS_CLK(SYS_CLK),
    .NRST(NRST), .LANE_LOCK(LANE_LOCK), .LANES_DESKEWED(LANES_DESKEWED),
    .RESTART_REQ(RESTART_REQ), .SINGLE_LANE_REQ(SINGLE_LANE_REQ),
    .ALT_LANE_PREF(ALT_LANE_PREF), .RX_STATUS_OK(RX_STATUS_OK), .RX_ERROR(RX_ERROR),
    .PKT_REQ(PKT_REQ), .ACK_REQ(ACK_REQ), .RESP_REQ(RESP_REQ), .CSYM_REQ(CSYM_REQ),
    .CSYM_IS_FRAME(CSYM_IS_FRAME), .CSYM_HAS_BUF(CSYM_HAS_BUF), .LANE_DRV_EN(LANE_DRV_EN),
    .LINK_UP(LINK_UP), .WIDE_MODE(WIDE_MODE), .ALT_LANE_SEL(ALT_LANE_SEL),
    .NORMAL_OP(NORMAL_OP), .TX_CHAR(TX_CHAR), .TX_CHAR_K(TX_CHAR_K),
    .TX_STATUS_SYM(TX_STATUS_SYM), .TX_CSYM_GNT(TX_CSYM_GNT), .TX_ACK_GNT(TX_ACK_GNT),
    .TX_PKT_GNT(TX_PKT_GNT), .TX_RESP_GNT(TX_RESP_GNT));
  mlis_peer_model i_peer (.clk(SYS_CLK), .nrst(NRST), .drv_en(LANE_DRV_EN),
    .link_up(LINK_UP), .lane_ok(lane_ok), .wide_ok(wide_ok), .status_go(status_go),
    .err_go(err_go), .lane_lock(LANE_LOCK), .deskewed(LANES_DESKEWED),
    .status_ok(RX_STATUS_OK), .rx_error(RX_ERROR));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge SYS_CLK);
  endtask
  task automatic wait_sig(input int b, input int lim, output int k);
    k = 0;
    do begin
      @(posedge SYS_CLK);
      k++;
    end while (sig[b] !== 1'b1 && k < lim);
  endtask
  task automatic restart(input logic [3:0] ok, input logic wd);
    lane_ok     <= ok;
    wide_ok     <= wd;
    RESTART_REQ <= 1'b1;
    @(posedge SYS_CLK);
    RESTART_REQ <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic t_listen;
    cyc(5);
    chk(LANE_DRV_EN, 4'h0, "quiet drivers");
    cyc(QC);
    chk(LANE_DRV_EN, 4'h5, "listen drivers");
    chk(LINK_UP, 1'b0, "listen link");
    chk(TX_CHAR, CHAR_IDLE_K, "listen char");
    $display("test listen done");
  endtask
  // Forced narrow must come up well before a probe window could end.
  task automatic t_force;
    for (int k = 0; k < 2; k++) begin
      SINGLE_LANE_REQ <= 1'b1;
      ALT_LANE_PREF   <= k[0];
      restart(k[0] ? 4'h5 : 4'h1, 1'b0);
      cyc(QC + 6);
      chk(LINK_UP, 1'b1, "forced link");
      chk(ALT_LANE_SEL, k[0], "forced lane");
    end
    SINGLE_LANE_REQ <= 1'b0;
    ALT_LANE_PREF   <= 1'b0;
    $display("test force done");
  endtask
  task automatic t_narrow;
    for (int k = 0; k < 2; k++) begin
      restart(k[0] ? 4'h4 : 4'h1, 1'b0);
      cyc(QC + 6);
      chk(LANE_DRV_EN, 4'hF, "probe drivers");
      chk(LINK_UP, 1'b0, "probe link");
      wait_sig(5, PC + 10, n);
      chk(WIDE_MODE, 1'b0, "narrow width");
      chk(ALT_LANE_SEL, k[0], "narrow lane");
    end
    lane_ok <= 4'h0;
    cyc(4);
    chk(LANE_DRV_EN, 4'h0, "lock loss");
    restart(4'h5, 1'b0);
    cyc(QC + 6);
    lane_ok <= 4'h0;
    cyc(4);
    chk(LANE_DRV_EN, 4'h0, "probe loss");
    $display("test narrow done");
  endtask
  task automatic t_wide;
    PKT_REQ <= 1'b1;
    restart(4'hF, 1'b1);
    wait_sig(5, QC + PC + 20, n);
    chk(WIDE_MODE, 1'b1, "wide mode");
    wait_sig(0, 300, n);
    wait_sig(0, 300, n);
    chk(n[11:0], 12'h100, "seek status gap");
    status_go <= 1'b1;
    cyc(10);
    err_go <= 1'b1;
    @(posedge SYS_CLK);
    err_go <= 1'b0;
    cyc(12);
    chk(NORMAL_OP, 1'b0, "normal after error");
    wait_sig(6, 200, n);
    chk(NORMAL_OP, 1'b1, "normal reached");
    wait_sig(3, 50, n);
    PKT_REQ  <= 1'b0;
    RESP_REQ <= 1'b1;
    chk(TX_PKT_GNT, 1'b1, "packet grant");
    wait_sig(4, 20, n);
    chk(TX_RESP_GNT, 1'b0, "response held");
    ACK_REQ <= 1'b1;
    wait_sig(2, 20, n);
    ACK_REQ <= 1'b0;
    wait_sig(4, 20, n);
    RESP_REQ <= 1'b0;
    chk(TX_RESP_GNT, 1'b1, "response after ack");
    for (int k = 0; k < 2; k++) begin
      CSYM_IS_FRAME <= k[0];
      CSYM_HAS_BUF  <= k[0];
      CSYM_REQ      <= 1'b1;
      wait_sig(1, 20, n);
      CSYM_REQ <= 1'b0;
      chk(TX_CHAR, k[0] ? CHAR_FRAME_K : CHAR_PLAIN_K, "symbol marker");
      @(posedge SYS_CLK);
    end
    wait_sig(0, 260, n);
    chk(TX_STATUS_SYM, 1'b1, "normal status refresh");
    chk(n[11:0], 12'h100, "buffer symbol restarts gap");
    wide_ok <= 1'b0;
    cyc(4);
    chk(LANE_DRV_EN, 4'hF, "wide loss drivers");
    chk(LINK_UP, 1'b0, "wide loss probe");
    $display("test wide done");
  endtask
  initial begin
    cyc(8);
    NRST <= 1'b1;
    t_listen;
    t_force;
    t_narrow;
    t_wide;
    test_done;
  end
  initial begin
    #50000;
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    test_done;
  end
endmodule

// ---- verif/mlis_peer_model.sv ----
// Behavioural model of the peer port across the lanes.
`timescale 1ns/1ps
module mlis_peer_model (
  input  wire logic       clk,        // Character clock.
  input  wire logic       nrst,       // Reset, active low.
  input  wire logic [3:0] drv_en,     // Local drivers seen by the peer.
  input  wire logic       link_up,    // Local port initialized.
  input  wire logic [3:0] lane_ok,    // Lanes the channel carries.
  input  wire logic       wide_ok,    // Peer can run four lanes.
  input  wire logic       status_go,  // Peer has come up itself.
  input  wire logic       err_go,     // Inject one receive error.
  output logic      [3:0] lane_lock,  // Lock per lane.
  output logic            deskewed,   // All lanes aligned.
  output logic            status_ok,  // Status symbol received.
  output logic            rx_error    // Receive error.
);
  logic [1:0] gap_r;
  // Lock follows the local drivers, so silence makes the peer lose lock.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lane_lock <= 4'h0;
      deskewed  <= 1'b0;
    end else begin
      lane_lock <= drv_en & lane_ok;
      deskewed  <= wide_ok && (&(drv_en & lane_ok));
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_r     <= 2'h0;
      status_ok <= 1'b0;
      rx_error  <= 1'b0;
    end else begin
      gap_r     <= gap_r + 2'h1;
      status_ok <= status_go && link_up && (gap_r == 2'h3);
      rx_error  <= err_go && link_up;
    end
  end
endmodule
